// ### logic/vic_defines.svh
// Purpose: Offsets, field positions, reset values of the vectored interrupt controller
// Assumes: Register bus carries byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

`define VIC_ADDR_W          12
`define VIC_OFF_VEC_TABLE   12'h080
`define VIC_OFF_NORM_VEC    12'h100
`define VIC_OFF_FAST_VEC    12'h104
`define VIC_OFF_CUR_SRC     12'h108
`define VIC_OFF_PENDING     12'h10c
`define VIC_OFF_ENABLE      12'h110
`define VIC_OFF_CORE_LINE   12'h114
`define VIC_OFF_EN_CMD      12'h120
`define VIC_OFF_DIS_CMD     12'h124
`define VIC_OFF_CLR_CMD     12'h128
`define VIC_OFF_SET_CMD     12'h12c
`define VIC_OFF_EOS_CMD     12'h130
`define VIC_OFF_SPUR_VEC    12'h134
`define VIC_FAST_SRC        5'h00
`define VIC_BIT_FAST_LINE   0
`define VIC_BIT_NORM_LINE   1
`define VIC_RST_WORD        32'h0000_0000

`endif

// ### logic/vic_pkg.sv
// Purpose: Types of the vectored interrupt controller
// Assumes: Thirty-two sources
// Notes:   Constants live in vic_defines.svh
package vic_pkg;
   typedef logic [31:0] vic_word_t;
   typedef logic [4:0]  vic_src_t;
   typedef enum logic [1:0] {
      VIC_IDLE    = 2'b01,
      VIC_SERVICE = 2'b10
   } vic_state_e;
endpackage

// ### logic/vic_regs.sv
// Purpose: Register view of a 32-source vectored interrupt controller
// Assumes: Sources are asynchronous requests captured on rising edges, source 0 is the fast one
// Notes:   Read data stand one cycle after the read strobe
`timescale 1ns/1ps
`include "vic_defines.svh"

// Behaviour
// RULE1: Fast vector read returns the handler address stored for source 0.
// RULE2: Without an active fast request, fast vector read returns the spurious vector.
// RULE3: Current source register shows serviced source number, other bits zero.
// RULE4: Bit 0 fast source, bit 1 system source, bits 2-31 peripherals.
// RULE5: Pending register shows one per pending source, zero otherwise.
// RULE6: Enable register shows one per enabled source; resets to zero.
// RULE7: Core line register bit 0 is one while fast line is asserted.
// RULE8: Core line register bit 1 is one while normal line is asserted.
// RULE9: Writing ones to enable command enables sources; zeros change nothing.
// RULE10: Writing ones to disable command disables sources; zeros change nothing.
// RULE11: Writing ones to clear command clears pending; zeros do nothing.
// RULE12: Writing ones to set command forces pending; zeros do nothing.
// RULE13: Service software writes end-of-service once handling is finished.
// RULE14: Any write to end-of-service completes service, whatever the data.
// RULE15: Source 0 is the fast source and ignores priority.
// RULE16: A read/write spurious vector register holds the spurious handler address.
// RULE17: Reads of command registers return zero with no side effect.
module vic_regs (
   input  wire logic                      i_mclk,
   input  wire logic                      i_arst_n,
   input  wire logic [31:0]               i_src_req,
   input  wire logic [`VIC_ADDR_W-1:0]    i_addr,
   input  wire logic [31:0]               i_wdata,
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   output logic      [31:0]               o_rdata,
   output logic                           o_fast_request_line_n,
   output logic                           o_normal_request_line_n
);

   logic [31:0]        req_meta;
   logic [31:0]        req_sync;
   logic [31:0]        req_prev;
   logic [31:0]        pending;
   logic [31:0]        enable_mask;
   logic [31:0]        next_enable;
   logic               next_norm_any;
   vic_pkg::vic_word_t source_vector_table [32];
   vic_pkg::vic_word_t spurious_vector_reg;
   vic_pkg::vic_src_t  current_source_number;
   vic_pkg::vic_state_e state;
   vic_pkg::vic_state_e next_state;
   logic [31:0]        next_pending;
   logic [31:0]        rise;
   logic [31:0]        active;
   logic               norm_cand;
   vic_pkg::vic_src_t  norm_src;
   logic               wr_en;
   logic               wr_dis;
   logic               wr_clr;
   logic               wr_set;
   logic               wr_eos;
   logic               rd_norm;
   logic               tbl_hit;
   vic_pkg::vic_word_t next_rdata;

   // Source inputs come from outside the clock domain
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         req_meta <= `VIC_RST_WORD;
         req_sync <= `VIC_RST_WORD;
         req_prev <= `VIC_RST_WORD;
      end else begin
         req_meta <= i_src_req;
         req_sync <= req_meta;
         req_prev <= req_sync;
      end
   end

   assign rise   = req_sync & ~req_prev;
   assign wr_en  = i_wr && (i_addr == `VIC_OFF_EN_CMD);
   assign wr_dis = i_wr && (i_addr == `VIC_OFF_DIS_CMD);
   assign wr_clr = i_wr && (i_addr == `VIC_OFF_CLR_CMD);
   assign wr_set = i_wr && (i_addr == `VIC_OFF_SET_CMD);
   assign wr_eos = i_wr && (i_addr == `VIC_OFF_EOS_CMD); // RULE14
   assign rd_norm = i_rd && (i_addr == `VIC_OFF_NORM_VEC);
   assign tbl_hit = (i_addr[`VIC_ADDR_W-1:7] == 5'(`VIC_OFF_VEC_TABLE >> 7));

   // Pending: edge captured, set wins over clear, per bit
   genvar g;
   generate
      for (g = 0; g < 32; g = g + 1) begin : g_pend
         always_comb begin
            next_pending[g] = pending[g];
            if (wr_clr && i_wdata[g]) begin
               next_pending[g] = 1'b0; // RULE11
            end
            if (rd_norm && state == vic_pkg::VIC_IDLE && norm_cand
                && norm_src == 5'(g)) begin
               next_pending[g] = 1'b0;
            end
            if (rise[g] || (wr_set && i_wdata[g])) begin
               next_pending[g] = 1'b1; // RULE12
            end
         end
      end
   endgenerate

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pending <= `VIC_RST_WORD;
      end else begin
         pending <= next_pending; // RULE5
      end
   end

   // Next mask also feeds the lines, so a command moves them on its own edge
   always_comb begin
      next_enable = enable_mask;
      if (wr_en) begin
         next_enable = enable_mask | i_wdata; // RULE9
      end else if (wr_dis) begin
         next_enable = enable_mask & ~i_wdata; // RULE10
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         enable_mask <= `VIC_RST_WORD; // RULE6
      end else begin
         enable_mask <= next_enable;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         spurious_vector_reg <= `VIC_RST_WORD;
      end else if (i_wr && i_addr == `VIC_OFF_SPUR_VEC) begin
         spurious_vector_reg <= i_wdata; // RULE16
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int k = 0; k < 32; k++) begin
            source_vector_table[k] <= `VIC_RST_WORD;
         end
      end else if (i_wr && tbl_hit) begin
         source_vector_table[i_addr[6:2]] <= i_wdata;
      end
   end

   assign active = pending & enable_mask;
   assign next_norm_any = |(next_pending[31:1] & next_enable[31:1]); // RULE15

   // Lowest-numbered active normal source wins; source 0 never takes part
   always_comb begin
      norm_cand = 1'b0;
      norm_src  = 5'h01;
      for (int k = 31; k >= 1; k--) begin
         if (active[k]) begin
            norm_cand = 1'b1;
            norm_src  = 5'(k); // RULE15
         end
      end
   end

   // Service: a normal vector read takes the source, end-of-service returns
   always_comb begin
      next_state = state;
      case (state)
         vic_pkg::VIC_IDLE: begin
            if (rd_norm && norm_cand) begin
               next_state = vic_pkg::VIC_SERVICE;
            end
         end
         vic_pkg::VIC_SERVICE: begin
            if (wr_eos) begin
               next_state = vic_pkg::VIC_IDLE; // RULE14
            end
         end
         default: next_state = vic_pkg::VIC_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state                 <= vic_pkg::VIC_IDLE;
         current_source_number <= 5'h00;
      end else begin
         state <= next_state;
         if (state == vic_pkg::VIC_IDLE && rd_norm && norm_cand) begin
            current_source_number <= norm_src; // RULE3
         end
      end
   end

   // Lines are active low; normal line masked while a source is in service
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_fast_request_line_n   <= 1'b1;
         o_normal_request_line_n <= 1'b1;
      end else begin
         o_fast_request_line_n   <= ~(next_pending[`VIC_FAST_SRC] & next_enable[`VIC_FAST_SRC]);
         o_normal_request_line_n <= ~(next_norm_any && next_state == vic_pkg::VIC_IDLE);
      end
   end

   always_comb begin
      next_rdata = `VIC_RST_WORD; // RULE17
      if (tbl_hit) begin
         next_rdata = source_vector_table[i_addr[6:2]];
      end else begin
         case (i_addr)
            `VIC_OFF_NORM_VEC: begin
               next_rdata = norm_cand ? source_vector_table[norm_src]
                                      : spurious_vector_reg;
            end
            `VIC_OFF_FAST_VEC: begin
               next_rdata = !o_fast_request_line_n
                            ? source_vector_table[`VIC_FAST_SRC] // RULE1
                            : spurious_vector_reg;               // RULE2
            end
            `VIC_OFF_CUR_SRC:  next_rdata = {27'h0, current_source_number}; // RULE3
            `VIC_OFF_PENDING:  next_rdata = pending;      // RULE4
            `VIC_OFF_ENABLE:   next_rdata = enable_mask;  // RULE6
            `VIC_OFF_CORE_LINE: begin
               next_rdata[`VIC_BIT_FAST_LINE] = ~o_fast_request_line_n;   // RULE7
               next_rdata[`VIC_BIT_NORM_LINE] = ~o_normal_request_line_n; // RULE8
            end
            `VIC_OFF_SPUR_VEC: next_rdata = spurious_vector_reg;
            default:           next_rdata = `VIC_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata <= `VIC_RST_WORD;
      end else begin
         o_rdata <= i_rd ? next_rdata : `VIC_RST_WORD;
      end
   end

endmodule

// ### verification/vic_regs_checker.sv
// Purpose: Port assertions for vic_regs
// Assumes: Read data stand only in the cycle after the read strobe
// Notes:   Bound to every vic_regs instance
`timescale 1ns/1ps
`include "vic_defines.svh"
module vic_regs_checker (
   input wire logic                   i_mclk,
   input wire logic                   i_arst_n,
   input wire logic [31:0]            i_src_req,
   input wire logic [`VIC_ADDR_W-1:0] i_addr,
   input wire logic [31:0]            i_wdata,
   input wire logic                   i_wr,
   input wire logic                   i_rd,
   input wire logic [31:0]            o_rdata,
   input wire logic                   o_fast_request_line_n,
   input wire logic                   o_normal_request_line_n
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   a_cmd_rd_zero: assert property ($past(i_rd) && ($past(i_addr) inside {[12'h120:12'h130]})
      |-> o_rdata == 32'h0) else $error("command register read not zero");
   a_cur_src_field: assert property ($past(i_rd && i_addr == 12'h108)
      |-> o_rdata[31:5] == 27'h0) else $error("current source upper bits set");
   a_fast_line_bit: assert property ($past(i_rd && i_addr == 12'h114)
      |-> o_rdata[0] == !$past(o_fast_request_line_n)) else $error("fast line status wrong");
   a_norm_line_bit: assert property ($past(i_rd && i_addr == 12'h114)
      |-> o_rdata[1] == !$past(o_normal_request_line_n)) else $error("normal line status wrong");
   a_core_upper_zero: assert property ($past(i_rd && i_addr == 12'h114)
      |-> o_rdata[31:2] == 30'h0) else $error("core line upper bits set");
   a_dis_drops_fast: assert property ($past(i_wr && i_addr == 12'h124 && i_wdata[0])
      |-> o_fast_request_line_n) else $error("fast line low after disable");
   a_pend_fast_bit: assert property ($past(i_rd && i_addr == 12'h10c && !o_fast_request_line_n)
      |-> o_rdata[0]) else $error("fast source not shown pending");
   a_en_fast_bit: assert property ($past(i_rd && i_addr == 12'h110 && !o_fast_request_line_n)
      |-> o_rdata[0]) else $error("fast source not shown enabled");
endmodule
bind vic_regs vic_regs_checker vic_regs_checker_i (.i_mclk, .i_arst_n, .i_src_req, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .o_fast_request_line_n, .o_normal_request_line_n);

// ### verification/vic_core_model.sv
// Purpose: Core model counting fast and normal request entries
// Assumes: Request lines are active low levels
// Notes:   An entry is a falling edge of a line
`timescale 1ns/1ps
module vic_core_model (
   input  wire logic       i_mclk,
   input  wire logic       i_arst_n,
   input  wire logic       i_fast_request_line_n,
   input  wire logic       i_normal_request_line_n,
   output logic      [7:0] o_fast_entries,
   output logic      [7:0] o_normal_entries
);
   logic fast_q;
   logic norm_q;
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fast_q           <= 1'b1;
         norm_q           <= 1'b1;
         o_fast_entries   <= 8'h0;
         o_normal_entries <= 8'h0;
      end else begin
         fast_q <= i_fast_request_line_n;
         norm_q <= i_normal_request_line_n;
         if (fast_q && !i_fast_request_line_n) o_fast_entries <= o_fast_entries + 8'h1;
         if (norm_q && !i_normal_request_line_n) o_normal_entries <= o_normal_entries + 8'h1;
      end
   end
endmodule

// ### verification/vic_regs_tb_top.sv
// Purpose: Self-checking bench for vic_regs
// Assumes: Read data sampled in the cycle after the read strobe
// Notes:   Table rows first, then source edge and mid-run reset
`timescale 1ns/1ps
module vic_regs_tb_top;
   typedef struct {logic rd; logic [11:0] addr; logic [31:0] val;} vic_row_s;
   logic        i_mclk = 1'b0;
   logic        i_arst_n = 1'b0;
   logic [31:0] i_src_req = 32'h0;
   logic [11:0] i_addr = 12'h0;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic        o_fast_request_line_n;
   logic        o_normal_request_line_n;
   logic [7:0]  fast_cnt;
   logic [7:0]  norm_cnt;
   int          mismatches = 0;
   int          n_tests = 0;
   int          cyc = 0;
   vic_row_s    rows [$] = '{
      '{1'b1,12'h110,32'h0}, '{1'b1,12'h10c,32'h0}, '{1'b1,12'h114,32'h0},
      '{1'b0,12'h134,32'h5a5c}, '{1'b0,12'h080,32'h1230}, '{1'b1,12'h134,32'h5a5c},
      '{1'b1,12'h104,32'h5a5c}, '{1'b1,12'h118,32'h0},
      '{1'b0,12'h120,32'h5}, '{1'b0,12'h120,32'h0}, '{1'b1,12'h110,32'h5},
      '{1'b0,12'h124,32'h4}, '{1'b1,12'h110,32'h1},
      '{1'b0,12'h12c,32'h1}, '{1'b1,12'h10c,32'h1}, '{1'b1,12'h114,32'h1},
      '{1'b1,12'h104,32'h1230}, '{1'b1,12'h120,32'h0}, '{1'b1,12'h110,32'h1},
      '{1'b0,12'h124,32'h1}, '{1'b1,12'h114,32'h0}, '{1'b0,12'h120,32'h1},
      '{1'b0,12'h128,32'h1}, '{1'b1,12'h10c,32'h0}, '{1'b1,12'h114,32'h0},
      '{1'b0,12'h12c,32'h4}, '{1'b0,12'h120,32'h4}, '{1'b1,12'h114,32'h2},
      '{1'b1,12'h100,32'h0}, '{1'b1,12'h108,32'h2}, '{1'b1,12'h114,32'h0},
      '{1'b0,12'h130,32'hffffffff}, '{1'b0,12'h12c,32'h4}, '{1'b1,12'h114,32'h2}};

   vic_regs vic_regs_i (.i_mclk, .i_arst_n, .i_src_req, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .o_fast_request_line_n, .o_normal_request_line_n);
   vic_core_model vic_core_model_i (.i_mclk, .i_arst_n,
      .i_fast_request_line_n(o_fast_request_line_n),
      .i_normal_request_line_n(o_normal_request_line_n),
      .o_fast_entries(fast_cnt), .o_normal_entries(norm_cnt));

   initial begin
      forever #2 i_mclk = ~i_mclk;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge i_mclk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd   <= 1'b0;
      #1;
      chk($sformatf("read %h", a), e, o_rdata);
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         finish_test;
      end
   end

   initial begin
      repeat (10) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      foreach (rows[k]) begin
         if (rows[k].rd) rd(rows[k].addr, rows[k].val);
         else wr(rows[k].addr, rows[k].val);
      end
      chk("fast entries", 32'h2, {24'h0, fast_cnt});
      chk("normal entries", 32'h2, {24'h0, norm_cnt});
      @(posedge i_mclk);
      i_src_req <= 32'h8;
      repeat (4) @(posedge i_mclk);
      rd(12'h10c, 32'hc);
      @(posedge i_mclk);
      i_src_req <= 32'h0;
      wr(12'h128, 32'h8);
      rd(12'h10c, 32'h4);
      @(posedge i_mclk);
      i_arst_n <= 1'b0;
      @(posedge i_mclk);
      #1;
      chk("lines in reset", 32'h3, {30'h0, o_normal_request_line_n, o_fast_request_line_n});
      @(posedge i_mclk);
      i_arst_n <= 1'b1;
      rd(12'h110, 32'h0);
      finish_test;
   end
endmodule
